// ---- logic/fsps_top.sv ----
// Overview of operation
// - Code two: pin high while fill at/above threshold
// - Code three: high on full, low below threshold
// - Code four: high on RX overflow until flush
// - Code five: high on TX underflow until flush
//
// Register access over APB and the address map were decided locally.
`timescale 1ns/1ps
`include "fsps_defines.svh"
module fsps_top #(
  parameter int DEPTH  = 64,
  parameter int LVL_W  = 7,
  parameter int ADDR_W = 8
) (
  // Clock and reset
  input  wire logic              pclk,
  input  wire logic              presetn,
  // APB slave
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [31:0]       pwdata,
  input  wire logic [3:0]        pstrb,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  // FIFO side
  input  wire logic [LVL_W-1:0]  tx_level,
  input  wire logic              rx_overflow,
  input  wire logic              tx_underflow,
  input  wire logic              rx_flush,
  input  wire logic              tx_flush,
  // Status pin and interrupt
  output logic                   status_pin,
  output logic                   irq
);

  //////////////////////////////////////////////////////////////////////////////
  // Elaboration checks
  generate
    if (DEPTH < 2 || DEPTH >= (1 << LVL_W)) begin : g_bad_depth
      $error("fsps_top: DEPTH does not fit LVL_W");
    end
    if (LVL_W > 8 || ADDR_W < 5 || ADDR_W > 32) begin : g_bad_width
      $error("fsps_top: LVL_W or ADDR_W out of range");
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////////////
  // Functions
  function automatic fsps_pkg::fsps_hit_t fsps_decode(input logic [ADDR_W-1:0] a);
    fsps_pkg::fsps_hit_t h;
    h = '0;
    h[`FSPS_HIT_CTRL] = (a == ADDR_W'(`FSPS_OFS_CTRL));
    h[`FSPS_HIT_THR]  = (a == ADDR_W'(`FSPS_OFS_THR));
    h[`FSPS_HIT_STAT] = (a == ADDR_W'(`FSPS_OFS_STAT));
    h[`FSPS_HIT_EVT]  = (a == ADDR_W'(`FSPS_OFS_EVT));
    h[`FSPS_HIT_MASK] = (a == ADDR_W'(`FSPS_OFS_MASK));
    return h;
  endfunction

  // Codes outside the four served here select a low level
  function automatic logic fsps_pick(input fsps_pkg::fsps_sel_t s, input fsps_pkg::fsps_cond_t c);
    logic r;
    r = 1'b0;
    case (s)
      `FSPS_SEL_TX_THR:  r = c[`FSPS_C_THR];
      `FSPS_SEL_TX_FULL: r = c[`FSPS_C_FULL];
      `FSPS_SEL_RX_OVF:  r = c[`FSPS_C_OVF];
      `FSPS_SEL_TX_UNF:  r = c[`FSPS_C_UNF];
      default:           r = 1'b0;
    endcase
    return r;
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // Declarations
  fsps_link_if #(.LVL_W(LVL_W)) lk ();

  fsps_pkg::fsps_sel_t  sel_reg;
  logic                 inv_reg;
  logic [LVL_W-1:0]     thr_reg;
  fsps_pkg::fsps_cond_t mask_reg;
  logic                 pin_reg;
  logic [31:0]          rdata_reg;
  fsps_pkg::fsps_hit_t  hit;
  logic                 setup_ph;
  logic                 access_ph;
  logic                 wr_ok;
  logic                 sel_cond;
  logic [31:0]          rdata_next;

  //////////////////////////////////////////////////////////////////////////////
  // Submodules
  assign lk.tx_level     = tx_level;
  assign lk.thr          = thr_reg;
  assign lk.rx_overflow  = rx_overflow;
  assign lk.tx_underflow = tx_underflow;
  assign lk.rx_flush     = rx_flush;
  assign lk.tx_flush     = tx_flush;
  assign lk.mask         = mask_reg;

  fsps_cond #(
    .DEPTH (DEPTH),
    .LVL_W (LVL_W)
  ) u_cond (
    .pclk    (pclk),
    .presetn (presetn),
    .lk      (lk.cond_mp)
  );

  fsps_irq u_irq (
    .pclk    (pclk),
    .presetn (presetn),
    .lk      (lk.irq_mp)
  );

  //////////////////////////////////////////////////////////////////////////////
  // APB decode
  assign hit       = fsps_decode(paddr);
  assign setup_ph  = psel && !penable;
  assign access_ph = psel && penable;
  assign pready    = 1'b1;
  assign pslverr   = access_ph && (hit == '0);
  assign wr_ok     = access_ph && pwrite && pstrb[0];

  assign lk.evt_clr_we = wr_ok && hit[`FSPS_HIT_EVT];
  assign lk.evt_clr    = pwdata[`FSPS_NCOND-1:0];

  //////////////////////////////////////////////////////////////////////////////
  // Control register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sel_reg <= `FSPS_SEL_RST;
      inv_reg <= `FSPS_INV_RST;
    end else if (wr_ok && hit[`FSPS_HIT_CTRL]) begin
      sel_reg <= pwdata[`FSPS_CTRL_SEL_MSB:`FSPS_CTRL_SEL_LSB];
      inv_reg <= pwdata[`FSPS_CTRL_INV];
    end
  end

  // Threshold register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      thr_reg <= LVL_W'(`FSPS_THR_RST);
    end else if (wr_ok && hit[`FSPS_HIT_THR]) begin
      thr_reg <= pwdata[LVL_W-1:0];
    end
  end

  // Interrupt mask
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mask_reg <= `FSPS_MASK_RST;
    end else if (wr_ok && hit[`FSPS_HIT_MASK]) begin
      mask_reg <= pwdata[`FSPS_NCOND-1:0];
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Status pin
  assign sel_cond = fsps_pick(sel_reg, lk.cond);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_reg <= 1'b0;
    end else begin
      pin_reg <= sel_cond ^ inv_reg;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Read data, captured in the setup cycle
  always_comb begin
    rdata_next = '0;
    case (1'b1)
      hit[`FSPS_HIT_CTRL]: begin
        rdata_next[`FSPS_CTRL_SEL_MSB:`FSPS_CTRL_SEL_LSB] = sel_reg;
        rdata_next[`FSPS_CTRL_INV]                        = inv_reg;
      end
      hit[`FSPS_HIT_THR]: begin
        rdata_next[LVL_W-1:0] = thr_reg;
      end
      hit[`FSPS_HIT_STAT]: begin
        rdata_next[`FSPS_NCOND-1:0]                           = lk.cond;
        rdata_next[`FSPS_STAT_PIN]                            = pin_reg;
        rdata_next[`FSPS_STAT_SELC]                           = sel_cond;
        rdata_next[`FSPS_STAT_LVL_LSB +: LVL_W]               = tx_level;
      end
      hit[`FSPS_HIT_EVT]: begin
        rdata_next[`FSPS_NCOND-1:0] = lk.evt;
      end
      hit[`FSPS_HIT_MASK]: begin
        rdata_next[`FSPS_NCOND-1:0] = mask_reg;
      end
      default: begin
        rdata_next = '0;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdata_reg <= '0;
    end else if (setup_ph && !pwrite) begin
      rdata_reg <= rdata_next;
    end
  end

  assign prdata     = rdata_reg;
  assign status_pin = pin_reg;
  assign irq        = lk.irq;
endmodule

// ---- logic/fsps_defines.svh ----
`ifndef FSPS_DEFINES_SVH
`define FSPS_DEFINES_SVH

// Register byte offsets
`define FSPS_OFS_CTRL   8'h00
`define FSPS_OFS_THR    8'h04
`define FSPS_OFS_STAT   8'h08
`define FSPS_OFS_EVT    8'h0C
`define FSPS_OFS_MASK   8'h10

// One-hot register hit positions
`define FSPS_HIT_CTRL   0
`define FSPS_HIT_THR    1
`define FSPS_HIT_STAT   2
`define FSPS_HIT_EVT    3
`define FSPS_HIT_MASK   4
`define FSPS_NREG       5

// Selection codes routed to the pin
`define FSPS_SEL_TX_THR  6'h02
`define FSPS_SEL_TX_FULL 6'h03
`define FSPS_SEL_RX_OVF  6'h04
`define FSPS_SEL_TX_UNF  6'h05

// Condition vector bit positions
`define FSPS_C_THR      0
`define FSPS_C_FULL     1
`define FSPS_C_OVF      2
`define FSPS_C_UNF      3
`define FSPS_NCOND      4

// Field layout
`define FSPS_CTRL_SEL_LSB 0
`define FSPS_CTRL_SEL_MSB 5
`define FSPS_CTRL_INV     6
`define FSPS_STAT_PIN     4
`define FSPS_STAT_SELC    5
`define FSPS_STAT_LVL_LSB 8

// Reset values
`define FSPS_SEL_RST    6'h02
`define FSPS_INV_RST    1'h0
`define FSPS_THR_RST    8'h20
`define FSPS_MASK_RST   4'h0

`endif

// ---- logic/fsps_pkg.sv ----
`include "fsps_defines.svh"
package fsps_pkg;
  typedef logic [`FSPS_NCOND-1:0] fsps_cond_t;
  typedef logic [`FSPS_NREG-1:0]  fsps_hit_t;
  typedef logic [5:0]             fsps_sel_t;
endpackage

// ---- logic/fsps_link_if.sv ----
`timescale 1ns/1ps
`include "fsps_defines.svh"
interface fsps_link_if #(
  parameter int LVL_W = 7
);
  logic [LVL_W-1:0]     tx_level;
  logic [LVL_W-1:0]     thr;
  logic                 rx_overflow;
  logic                 tx_underflow;
  logic                 rx_flush;
  logic                 tx_flush;
  fsps_pkg::fsps_cond_t cond;
  fsps_pkg::fsps_cond_t evt_clr;
  logic                 evt_clr_we;
  fsps_pkg::fsps_cond_t mask;
  fsps_pkg::fsps_cond_t evt;
  logic                 irq;

  modport cond_mp (
    input  tx_level, thr, rx_overflow, tx_underflow, rx_flush, tx_flush,
    output cond
  );
  modport irq_mp (
    input  cond, evt_clr, evt_clr_we, mask,
    output evt, irq
  );
endinterface

// ---- logic/fsps_cond.sv ----
`timescale 1ns/1ps
`include "fsps_defines.svh"
module fsps_cond #(
  parameter int DEPTH = 64,
  parameter int LVL_W = 7
) (
  // Clock and reset
  input wire logic    pclk,
  input wire logic    presetn,
  // Link to the top
  fsps_link_if.cond_mp lk
);
  localparam logic [LVL_W-1:0] FULL_LVL = LVL_W'(DEPTH);

  logic thr_reg;
  logic full_reg;
  logic ovf_reg;
  logic unf_reg;

  //////////////////////////////////////////////////////////////////////////////
  // Threshold level
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      thr_reg <= 1'b0;
    end else begin
      thr_reg <= (lk.tx_level >= lk.thr);
    end
  end

  // Full with hysteresis down to the threshold; setting wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      full_reg <= 1'b0;
    end else if (lk.tx_level == FULL_LVL) begin
      full_reg <= 1'b1;
    end else if (lk.tx_level < lk.thr) begin
      full_reg <= 1'b0;
    end
  end

  // Receive overflow held until flush; a new overflow wins over the flush
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ovf_reg <= 1'b0;
    end else if (lk.rx_overflow) begin
      ovf_reg <= 1'b1;
    end else if (lk.rx_flush) begin
      ovf_reg <= 1'b0;
    end
  end

  // Transmit underflow held until flush
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      unf_reg <= 1'b0;
    end else if (lk.tx_underflow) begin
      unf_reg <= 1'b1;
    end else if (lk.tx_flush) begin
      unf_reg <= 1'b0;
    end
  end

  always_comb begin
    lk.cond              = '0;
    lk.cond[`FSPS_C_THR]  = thr_reg;
    lk.cond[`FSPS_C_FULL] = full_reg;
    lk.cond[`FSPS_C_OVF]  = ovf_reg;
    lk.cond[`FSPS_C_UNF]  = unf_reg;
  end
endmodule

// ---- logic/fsps_irq.sv ----
`timescale 1ns/1ps
`include "fsps_defines.svh"
module fsps_irq (
  // Clock and reset
  input wire logic   pclk,
  input wire logic   presetn,
  // Link to the top
  fsps_link_if.irq_mp lk
);
  fsps_pkg::fsps_cond_t prev_reg;
  fsps_pkg::fsps_cond_t evt_reg;
  logic                 irq_reg;

  // Each rising condition sets a sticky bit; the set wins over a clearing write
  genvar gi;
  generate
    for (gi = 0; gi < `FSPS_NCOND; gi++) begin : g_evt
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          prev_reg[gi] <= 1'b0;
          evt_reg[gi]  <= 1'b0;
        end else begin
          prev_reg[gi] <= lk.cond[gi];
          if (lk.cond[gi] && !prev_reg[gi]) begin
            evt_reg[gi] <= 1'b1;
          end else if (lk.evt_clr_we && lk.evt_clr[gi]) begin
            evt_reg[gi] <= 1'b0;
          end
        end
      end
    end
  endgenerate

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= |(evt_reg & lk.mask);
    end
  end

  assign lk.evt = evt_reg;
  assign lk.irq = irq_reg;
endmodule

// ---- testbench/fsps_props.sv ----
`timescale 1ns/1ps
module fsps_props #(
  parameter int DEPTH  = 64,
  parameter int LVL_W  = 7,
  parameter int ADDR_W = 8
) (
  // Watched ports
  input wire logic              pclk,
  input wire logic              presetn,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [31:0]       pwdata,
  input wire logic [3:0]        pstrb,
  input wire logic              pslverr,
  input wire logic [LVL_W-1:0]  tx_level,
  input wire logic              rx_overflow,
  input wire logic              tx_underflow,
  input wire logic              rx_flush,
  input wire logic              tx_flush,
  input wire logic              status_pin
);
  logic [5:0]       sel_q;
  logic             inv_q;
  logic [LVL_W-1:0] thr_q;
  logic [3:0]       c_m;
  // Mirror of the written control fields
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sel_q <= 6'h02;
      inv_q <= 1'h0;
      thr_q <= LVL_W'(8'h20);
    end else if (psel && penable && pwrite && pstrb[0]) begin
      if (paddr == 8'h00) begin
        sel_q <= pwdata[5:0];
        inv_q <= pwdata[6];
      end
      if (paddr == 8'h04) begin
        thr_q <= pwdata[LVL_W-1:0];
      end
    end
  end
  // Expected conditions, set wins over clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      c_m <= 4'h0;
    end else begin
      c_m[0] <= tx_level >= thr_q;
      c_m[1] <= (tx_level == DEPTH) || (c_m[1] && tx_level >= thr_q);
      c_m[2] <= rx_overflow || (c_m[2] && !rx_flush);
      c_m[3] <= tx_underflow || (c_m[3] && !tx_flush);
    end
  end
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  a_thr_pin:
    assert property ($past(sel_q) == 6'h02 |-> status_pin == ($past(c_m[0]) ^ $past(inv_q))) else $error("pin code 2");
  a_full_pin:
    assert property (sel_q == 6'h03 |=> status_pin == $past(c_m[1] ^ inv_q)) else $error("pin code 3");
  a_ovf_pin:
    assert property (sel_q == 6'h04 |=> status_pin == $past(c_m[2] ^ inv_q)) else $error("pin code 4");
  a_unf_pin:
    assert property (sel_q == 6'h05 |=> status_pin == $past(c_m[3] ^ inv_q)) else $error("pin code 5");
  a_other_pin:
    assert property (!(sel_q inside {[6'h02:6'h05]}) |=> status_pin == $past(inv_q)) else $error("pin other code");
  a_bad_addr_err:
    assert property (pslverr == (psel && penable && !(paddr inside {8'h00, 8'h04, 8'h08, 8'h0C, 8'h10})))
      else $error("slave error wrong");
endmodule

// ---- testbench/fsps_host.sv ----
`timescale 1ns/1ps
module fsps_host (
  // Pin watched as a polled flag
  input  wire logic pclk,
  input  wire logic status_pin,
  output logic      seen
);
  always_ff @(posedge pclk) begin
    seen <= status_pin;
  end
endmodule

// ---- testbench/fifo_status_pin_select_bench.sv ----
`timescale 1ns/1ps
module fifo_status_pin_select_bench;
  localparam int DEPTH = 64;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0;
  logic [3:0]  pstrb = 4'hF;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [6:0]  tx_level = 7'h00;
  logic [3:0]  ev = 4'h0;
  logic        status_pin;
  logic        irq;
  logic        seen;
  logic [31:0] rd;
  logic        err;
  logic [16:0] s = 17'h177FE;
  logic [6:0]  lv;
  logic        f_m = 1'b0;
  logic [6:0]  l2 [4] = '{7'h40, 7'h08, 7'h07, 7'h30};
  int          n_mismatch = 0;
  int          comparisons = 0;
  always #12.5 pclk = ~pclk;
  fsps_top #(.DEPTH(DEPTH)) u_fsps_top (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .tx_level(tx_level), .rx_overflow(ev[0]), .tx_underflow(ev[1]), .rx_flush(ev[2]),
    .tx_flush(ev[3]), .status_pin(status_pin), .irq(irq));
  fsps_host u_fsps_host (.pclk(pclk), .status_pin(status_pin), .seen(seen));
  ////////////////////////////////////////
  function automatic logic [16:0] lfsr(input logic [16:0] v);
    return {v[15:0], v[16] ^ v[13]};
  endfunction
  task automatic end_of_test;
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    repeat (3) @(posedge pclk);
  endtask
  // Level held until the pin has settled and been polled; full tracked against threshold 8
  task automatic step(input logic [6:0] v);
    tx_level <= v;
    f_m = (v == 7'(DEPTH)) || (f_m && v >= 7'h08);
    repeat (4) @(posedge pclk);
  endtask
  task automatic pulse(input int k);
    ev <= 4'h1 << k;
    @(posedge pclk);
    ev <= 4'h0;
    repeat (3) @(posedge pclk);
  endtask
  ////////////////////////////////////////
  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, 8'h00, 32'h0);
    chk("ctrl", 32'h02, rd);
    apb(1'b0, 8'h04, 32'h0);
    chk("thr", 32'h20, rd);
    apb(1'b0, 8'h10, 32'h0);
    chk("mask", 32'h0, rd);
    apb(1'b0, 8'h14, 32'h0);
    chk("bad addr err", 32'h1, {31'h0, err});
    apb(1'b1, 8'h04, 32'h08);
    for (int c = 2; c < 6; c++) begin
      apb(1'b1, 8'h00, c);
      repeat (30) begin
        s = lfsr(s);
        lv = (s[6:0] > 7'(DEPTH)) ? 7'(DEPTH) : s[6:0];
        step(lv);
        if (c == 2) chk("pin thr", {31'h0, lv >= 7'h08}, {31'h0, seen});
        if (c == 3) chk("pin full rnd", {31'h0, f_m}, {31'h0, seen});
        if (c > 3) chk("pin idle", 32'h0, {31'h0, seen});
      end
    end
    apb(1'b1, 8'h00, 32'h03);
    foreach (l2[i]) begin
      step(l2[i]);
      chk("pin full", {31'h0, i < 2}, {31'h0, seen});
    end
    step(7'h00);
    apb(1'b1, 8'h0C, 32'h0F);
    apb(1'b1, 8'h00, 32'h04);
    pulse(0);
    chk("pin ovf", 32'h1, {31'h0, seen});
    pulse(3);
    chk("pin ovf held", 32'h1, {31'h0, seen});
    pulse(2);
    chk("pin ovf flushed", 32'h0, {31'h0, seen});
    apb(1'b1, 8'h00, 32'h05);
    pulse(1);
    pulse(2);
    chk("pin unf held", 32'h1, {31'h0, seen});
    apb(1'b1, 8'h00, 32'h46);
    chk("pin inverted", 32'h1, {31'h0, seen});
    apb(1'b1, 8'h00, 32'h06);
    chk("pin other", 32'h0, {31'h0, seen});
    pulse(3);
    apb(1'b1, 8'h00, 32'h05);
    chk("pin unf flushed", 32'h0, {31'h0, seen});
    apb(1'b0, 8'h0C, 32'h0);
    chk("events", 32'h0C, rd);
    chk("irq masked", 32'h0, {31'h0, irq});
    apb(1'b1, 8'h10, 32'h08);
    chk("irq", 32'h1, {31'h0, irq});
    apb(1'b1, 8'h0C, 32'h08);
    chk("irq cleared", 32'h0, {31'h0, irq});
    end_of_test;
  end
  initial begin
    #100000;
    n_mismatch++;
    end_of_test;
  end
endmodule
bind fsps_top fsps_props #(.DEPTH(DEPTH), .LVL_W(LVL_W), .ADDR_W(ADDR_W)) u_fsps_props (.pclk(pclk),
  .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
  .pstrb(pstrb), .pslverr(pslverr), .tx_level(tx_level), .rx_overflow(rx_overflow),
  .tx_underflow(tx_underflow), .rx_flush(rx_flush), .tx_flush(tx_flush), .status_pin(status_pin));
